/* board_test_pin_control.sv */
module board_test_pin_control #(
    parameter int UNIT_CYCLES = board_test_pkg::TIMEOUT_UNIT_CYCLES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Test command stream
    input wire logic test_load_start_in,
    input wire logic test_byte_valid_in,
    input wire logic [7:0] test_byte_in,
    input wire logic test_read_in,
    input wire logic [2:0] read_index_in,
    output logic [7:0] read_byte_out,
    output logic read_valid_out,
    // EEPROM configuration byte reader
    output logic eeprom_req_out,
    output logic [6:0] eeprom_dev_out,
    output logic [7:0] eeprom_loc_out,
    input wire logic eeprom_ack_in,
    input wire logic eeprom_nak_in,
    input wire logic [7:0] eeprom_data_in,
    // Mode and configuration status
    output logic test_mode_out,
    output logic normal_mode_out,
    output logic cfg_done_out,
    output logic [7:0] drive_power_mgmt_out,
    output logic power_mgmt_enable_out,
    // Drive initialization
    input wire logic drive_is_packet_in,
    input wire logic drive_has_power_mgmt_in,
    input wire logic reset_poll_start_in,
    input wire logic reset_poll_busy_in,
    output logic reset_restart_out,
    // Normal functional disk drive
    input wire logic [2:0] func_addr_in,
    input wire logic [1:0] func_cs_n_in,
    input wire logic func_reset_n_in,
    input wire logic func_wr_n_in,
    input wire logic func_rd_n_in,
    input wire logic func_dack_n_in,
    input wire logic [15:0] func_data_in,
    input wire logic func_data_drive_in,
    // Disk side pins
    output logic [2:0] disk_addr_out,
    output logic [1:0] disk_cs_n_out,
    output logic disk_reset_out_n,
    output logic disk_write_strobe_n_out,
    output logic disk_read_strobe_n_out,
    output logic disk_dma_ack_n_out,
    output logic [15:0] disk_data_bus_out,
    output logic disk_data_bus_oe_n_out,
    input wire logic [15:0] disk_data_bus_in,
    input wire logic disk_irq_in,
    input wire logic disk_io_ready_in,
    input wire logic disk_dma_req_in,
    input wire logic disk_iface_enable_in,
    input wire logic bus_power_good_in
);

    typedef enum logic [4:0] {
        ST_READ = 5'h01,
        ST_WAIT = 5'h02,
        ST_NORMAL = 5'h04,
        ST_TEST = 5'h08,
        ST_FALLBACK = 5'h10
    } mode_e;

    mode_e mode, next_mode;
    logic [1:0] cfg_idx, next_cfg_idx;
    logic [7:0] sig_lo, next_sig_lo;
    logic [7:0] power_mgmt, next_power_mgmt;
    logic [7:0] timeout_units, next_timeout_units;
    logic eeprom_req, next_eeprom_req;
    logic [7:0] load0, next_load0;
    logic [7:0] load1, next_load1;
    logic [7:0] load2, next_load2;
    logic [7:0] load3, next_load3;
    logic [2:0] load_cnt, next_load_cnt;
    logic test_mode, next_test_mode;
    logic [24:0] sync1, sync2, snap;
    logic [24:0] next_snap;
    logic [7:0] read_byte, next_read_byte;
    logic read_valid;
    logic restart;

    function automatic logic [7:0] cfg_loc(input logic [1:0] idx);
        case (idx)
            2'd0: cfg_loc = board_test_pkg::LOC_SIG_LO;
            2'd1: cfg_loc = board_test_pkg::LOC_SIG_HI;
            2'd2: cfg_loc = board_test_pkg::LOC_POWER_MGMT;
            default: cfg_loc = board_test_pkg::LOC_INIT_TIMEOUT;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Power-up configuration fetch and mode selection
    // ------------------------------------------------------------
    always_comb begin
        next_mode = mode;
        next_cfg_idx = cfg_idx;
        next_sig_lo = sig_lo;
        next_power_mgmt = power_mgmt;
        next_timeout_units = timeout_units;
        next_eeprom_req = 1'b0;
        case (mode)
            ST_READ: begin
                next_eeprom_req = 1'b1;
                next_mode = ST_WAIT;
            end
            ST_WAIT: begin
                if (eeprom_nak_in) begin
                    next_mode = ST_FALLBACK;
                end else if (eeprom_ack_in) begin
                    next_mode = ST_READ;
                    next_cfg_idx = cfg_idx + 2'd1;
                    case (cfg_idx)
                        2'd0: next_sig_lo = eeprom_data_in;
                        2'd1: begin
                            if (sig_lo != board_test_pkg::SIGNATURE ||
                                eeprom_data_in !=
                                board_test_pkg::SIGNATURE) begin
                                next_mode = ST_FALLBACK;
                            end
                        end
                        2'd2: next_power_mgmt = eeprom_data_in;
                        default: begin
                            next_timeout_units = eeprom_data_in;
                            next_mode = ST_NORMAL;
                        end
                    endcase
                end
            end
            default: next_mode = mode;
        endcase
        // Test mode is final
        if (test_mode) begin
            next_mode = ST_TEST;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            mode <= ST_READ;
            cfg_idx <= 2'd0;
            sig_lo <= 8'h00;
            power_mgmt <= board_test_pkg::POWER_MGMT_OFF;
            timeout_units <= 8'h00;
            eeprom_req <= 1'b0;
        end else begin
            mode <= next_mode;
            cfg_idx <= next_cfg_idx;
            sig_lo <= next_sig_lo;
            power_mgmt <= next_power_mgmt;
            timeout_units <= next_timeout_units;
            eeprom_req <= next_eeprom_req;
        end
    end

    // ------------------------------------------------------------
    // Test load payload capture
    // ------------------------------------------------------------
    always_comb begin
        next_load0 = load0;
        next_load1 = load1;
        next_load2 = load2;
        next_load3 = load3;
        next_load_cnt = load_cnt;
        next_test_mode = test_mode;
        if (test_load_start_in) begin
            next_test_mode = 1'b1;
            next_load_cnt = 3'd0;
        end else if (test_byte_valid_in && test_mode &&
                     load_cnt < 3'(board_test_pkg::LOAD_BYTES)) begin
            next_load_cnt = load_cnt + 3'd1;
            case (load_cnt)
                3'd0: next_load0 = test_byte_in;
                3'd1: next_load1 = test_byte_in;
                3'd2: next_load2 = test_byte_in;
                3'd3: next_load3 = test_byte_in;
                default: next_load0 = load0;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            load0 <= board_test_pkg::LOAD0_RESET;
            load1 <= board_test_pkg::LOAD1_RESET;
            load2 <= 8'h00;
            load3 <= 8'h00;
            load_cnt <= 3'd0;
            test_mode <= 1'b0;
        end else begin
            load0 <= next_load0;
            load1 <= next_load1;
            load2 <= next_load2;
            load3 <= next_load3;
            load_cnt <= next_load_cnt;
            test_mode <= next_test_mode;
        end
    end

    // ------------------------------------------------------------
    // Output pin multiplexing
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            disk_addr_out <= 3'h0;
            disk_cs_n_out <= 2'h3;
            disk_reset_out_n <= 1'b1;
            disk_write_strobe_n_out <= 1'b1;
            disk_read_strobe_n_out <= 1'b1;
            disk_dma_ack_n_out <= 1'b1;
            disk_data_bus_out <= 16'h0000;
            disk_data_bus_oe_n_out <= 1'b1;
        end else if (test_mode) begin
            disk_addr_out <= load0[board_test_pkg::LD0_ADDR_LO +: 3];
            disk_cs_n_out <= load0[board_test_pkg::LD0_CS_LO +: 2];
            disk_reset_out_n <= load0[board_test_pkg::LD0_RESET];
            disk_write_strobe_n_out <= load1[board_test_pkg::LD1_WR];
            disk_read_strobe_n_out <= load1[board_test_pkg::LD1_RD];
            disk_dma_ack_n_out <= load1[board_test_pkg::LD1_DACK];
            disk_data_bus_out <= {load3, load2};
            disk_data_bus_oe_n_out <=
                !load1[board_test_pkg::LD1_DATA_OE];
        end else if (mode == ST_NORMAL) begin
            disk_addr_out <= func_addr_in;
            disk_cs_n_out <= func_cs_n_in;
            disk_reset_out_n <= func_reset_n_in;
            disk_write_strobe_n_out <= func_wr_n_in;
            disk_read_strobe_n_out <= func_rd_n_in;
            disk_dma_ack_n_out <= func_dack_n_in;
            disk_data_bus_out <= func_data_in;
            disk_data_bus_oe_n_out <= !func_data_drive_in;
        end else begin
            disk_addr_out <= 3'h0;
            disk_cs_n_out <= 2'h3;
            disk_reset_out_n <= 1'b1;
            disk_write_strobe_n_out <= 1'b1;
            disk_read_strobe_n_out <= 1'b1;
            disk_dma_ack_n_out <= 1'b1;
            disk_data_bus_out <= 16'h0000;
            disk_data_bus_oe_n_out <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Input snapshot and read-back
    // ------------------------------------------------------------
    always_comb begin
        next_snap = snap;
        if (test_read_in && (test_mode || mode == ST_FALLBACK)) begin
            next_snap = sync2;
        end
        next_read_byte = 8'h00;
        case (read_index_in)
            3'd0: begin
                next_read_byte[board_test_pkg::RD0_IRQ] = snap[0];
                next_read_byte[board_test_pkg::RD0_PWR] = snap[1];
                next_read_byte[board_test_pkg::RD0_RESET] =
                    disk_reset_out_n;
            end
            3'd1: begin
                next_read_byte[board_test_pkg::RD1_DISK_IO_READY_IN] = snap[2];
                next_read_byte[board_test_pkg::RD1_DREQ] = snap[3];
                next_read_byte[board_test_pkg::RD1_EN] = snap[4];
                next_read_byte[board_test_pkg::RD1_DATA_OE] =
                    load1[board_test_pkg::LD1_DATA_OE];
            end
            3'd2: next_read_byte = snap[12:5];
            3'd3: next_read_byte = snap[20:13];
            default: next_read_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            sync1 <= '0;
            sync2 <= '0;
            snap <= '0;
            read_byte <= 8'h00;
            read_valid <= 1'b0;
        end else begin
            sync1 <= {4'h0, disk_data_bus_in, disk_iface_enable_in,
                      disk_dma_req_in, disk_io_ready_in,
                      bus_power_good_in, disk_irq_in};
            sync2 <= sync1;
            snap <= next_snap;
            read_byte <= next_read_byte;
            read_valid <= test_mode || mode == ST_FALLBACK;
        end
    end

    // ------------------------------------------------------------
    // Drive initialization support
    // ------------------------------------------------------------
    init_timeout_timer #(
        .UNIT_CYCLES(UNIT_CYCLES)
    ) u_timer (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .start_in(reset_poll_start_in && mode == ST_NORMAL),
        .busy_in(reset_poll_busy_in),
        .units_in(timeout_units),
        .expired_out(restart)
    );

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            reset_restart_out <= 1'b0;
            power_mgmt_enable_out <= 1'b0;
            drive_power_mgmt_out <= 8'h00;
            eeprom_req_out <= 1'b0;
            eeprom_dev_out <= board_test_pkg::EEPROM_DEV_ADDR;
            eeprom_loc_out <= 8'h00;
            test_mode_out <= 1'b0;
            normal_mode_out <= 1'b0;
            cfg_done_out <= 1'b0;
            read_byte_out <= 8'h00;
            read_valid_out <= 1'b0;
        end else begin
            reset_restart_out <= restart;
            power_mgmt_enable_out <= mode == ST_NORMAL && !drive_is_packet_in &&
                drive_has_power_mgmt_in &&
                power_mgmt != board_test_pkg::POWER_MGMT_OFF;
            drive_power_mgmt_out <= power_mgmt;
            eeprom_req_out <= eeprom_req;
            eeprom_dev_out <= board_test_pkg::EEPROM_DEV_ADDR;
            eeprom_loc_out <= cfg_loc(cfg_idx);
            test_mode_out <= test_mode || mode == ST_FALLBACK;
            normal_mode_out <= mode == ST_NORMAL && !test_mode;
            cfg_done_out <= mode == ST_NORMAL || mode == ST_FALLBACK;
            read_byte_out <= read_byte;
            read_valid_out <= read_valid;
        end
    end

endmodule // board_test_pin_control

/* board_test_pkg.sv */
package board_test_pkg;

    // Load payload layout
    localparam int LOAD_BYTES = 7;
    localparam int READ_BYTES = 8;
    localparam logic [7:0] SUBCMD_TEST = 8'h27;
    localparam int LD0_ADDR_LO = 1;
    localparam int LD0_CS_LO = 4;
    localparam int LD0_RESET = 7;
    localparam int LD1_WR = 0;
    localparam int LD1_RD = 1;
    localparam int LD1_DACK = 2;
    localparam int LD1_DATA_OE = 7;

    // Manufacturing read layout
    localparam int RD0_IRQ = 0;
    localparam int RD0_PWR = 6;
    localparam int RD0_RESET = 7;
    localparam int RD1_DISK_IO_READY_IN = 3;
    localparam int RD1_DREQ = 4;
    localparam int RD1_EN = 5;
    localparam int RD1_DATA_OE = 7;

    // Configuration EEPROM
    localparam logic [6:0] EEPROM_DEV_ADDR = 7'h04;
    localparam int EEPROM_SIZE = 256;
    localparam logic [7:0] LOC_SIG_LO = 8'h00;
    localparam logic [7:0] LOC_SIG_HI = 8'h01;
    localparam logic [7:0] LOC_POWER_MGMT = 8'h02;
    localparam logic [7:0] LOC_INIT_TIMEOUT = 8'h03;
    localparam logic [7:0] SIGNATURE = 8'h4d;
    localparam logic [7:0] POWER_MGMT_OFF = 8'h00;
    localparam int CFG_BYTES = 4;

    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int TIMEOUT_UNIT_MS = 128;
    localparam int TIMEOUT_UNIT_CYCLES = CLK_HZ / 1000 * TIMEOUT_UNIT_MS;

    // Test drive reset values
    localparam logic [7:0] LOAD0_RESET = 8'h80;
    localparam logic [7:0] LOAD1_RESET = 8'h07;

endpackage : board_test_pkg

/* init_timeout_timer.sv */
module init_timeout_timer #(
    parameter int UNIT_CYCLES = board_test_pkg::TIMEOUT_UNIT_CYCLES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Control
    input wire logic start_in,
    input wire logic busy_in,
    input wire logic [7:0] units_in,
    // Status
    output logic expired_out
);

    localparam int PW = $clog2(UNIT_CYCLES + 1);

    logic [PW-1:0] prescale;
    logic [7:0] units;
    logic running;
    logic expired;
    logic [PW-1:0] next_prescale;
    logic [7:0] next_units;
    logic next_running;
    logic next_expired;

    // ------------------------------------------------------------
    // Count timeout units while polling
    // ------------------------------------------------------------
    always_comb begin
        next_prescale = prescale;
        next_units = units;
        next_running = running;
        next_expired = 1'b0;
        if (start_in) begin
            next_prescale = '0;
            next_units = units_in;
            next_running = 1'b1;
        end else if (running && !busy_in) begin
            next_running = 1'b0;
        end else if (running) begin
            if (prescale == PW'(UNIT_CYCLES - 1)) begin
                next_prescale = '0;
                if (units <= 8'h01) begin
                    next_running = 1'b0;
                    next_expired = 1'b1;
                end else begin
                    next_units = units - 8'h01;
                end
            end else begin
                next_prescale = prescale + PW'(1);
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            prescale <= '0;
            units <= 8'h00;
            running <= 1'b0;
            expired <= 1'b0;
        end else begin
            prescale <= next_prescale;
            units <= next_units;
            running <= next_running;
            expired <= next_expired;
        end
    end

    assign expired_out = expired;

endmodule // init_timeout_timer

/* cfg_eeprom_model.sv */
module cfg_eeprom_model (
    // Clock
    input wire logic clk_in,
    // Request from the block
    input wire logic req_in,
    input wire logic [6:0] dev_in,
    input wire logic [7:0] loc_in,
    // Contents and behaviour
    input wire logic present_in,
    input wire logic [31:0] cfg_in,
    input wire logic [3:0] lag_in,
    // Answer
    output logic ack_out,
    output logic nak_out,
    output logic [7:0] data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic pend = 1'b0;
    logic hit;
    logic [3:0] left;
    logic [7:0] loc;
    initial {ack_out, nak_out, data_out} = 10'h05a;
    always @(posedge clk_in) begin
        ack_out <= 1'b0;
        nak_out <= 1'b0;
        data_out <= ~data_out;
        if (req_in && !pend) begin
            pend <= 1'b1;
            left <= lag_in;
            loc <= loc_in;
            hit <= present_in && dev_in == 7'h04;
        end else if (pend && left > 4'h1) begin
            left <= left - 4'h1;
        end else if (pend) begin
            pend <= 1'b0;
            ack_out <= hit;
            nak_out <= !hit;
            data_out <= loc < 8'h04 ? cfg_in[8*loc[1:0] +: 8] : 8'hff;
        end
    end
endmodule // cfg_eeprom_model

/* board_test_pin_control_checker.sv */
module board_test_pin_control_checker #(
    parameter int UNIT_CYCLES = 10
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Watched ports
    input wire logic test_load_start_in,
    input wire logic test_mode_out,
    input wire logic read_valid_out,
    input wire logic eeprom_req_out,
    input wire logic [6:0] eeprom_dev_out,
    input wire logic [7:0] eeprom_loc_out,
    input wire logic eeprom_ack_in,
    input wire logic eeprom_nak_in,
    input wire logic [7:0] eeprom_data_in,
    input wire logic normal_mode_out,
    input wire logic [7:0] drive_power_mgmt_out,
    input wire logic power_mgmt_enable_out,
    input wire logic reset_poll_start_in,
    input wire logic reset_restart_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    int poll_cnt;
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || reset_poll_start_in) begin
            poll_cnt <= 0;
        end else if (poll_cnt < UNIT_CYCLES) begin
            poll_cnt <= poll_cnt + 1;
        end
    end
    AST_LOAD_ENTERS: assert property (
        test_load_start_in |-> ##[1:2] test_mode_out)
        else $error("no test mode");
    AST_MODE_STICKY: assert property (test_mode_out |=> test_mode_out)
        else $error("test mode left");
    AST_NAK_FALLBACK: assert property (
        eeprom_nak_in |-> ##[1:3] test_mode_out)
        else $error("no fallback");
    AST_EEPROM_ADDR: assert property (
        eeprom_req_out |-> eeprom_dev_out == 7'h04)
        else $error("bad device");
    AST_FIRST_REQ: assert property (
        $fell(sys_rst_in) |-> ##[0:2]
        (eeprom_req_out && eeprom_loc_out == 8'h00))
        else $error("no first read");
    AST_SIG_NEXT: assert property (
        eeprom_ack_in && eeprom_loc_out == 8'h00 && eeprom_data_in == 8'h4d
        |-> ##3 (eeprom_req_out && eeprom_loc_out == 8'h01))
        else $error("no second read");
    AST_BAD_SIG: assert property (
        eeprom_ack_in && eeprom_loc_out == 8'h01 && eeprom_data_in != 8'h4d
        |-> ##[1:3] test_mode_out)
        else $error("bad sig kept");
    AST_CFG_ORDER: assert property (
        eeprom_ack_in && eeprom_loc_out == 8'h02
        |-> ##3 (eeprom_req_out && eeprom_loc_out == 8'h03))
        else $error("no timeout read");
    AST_PM_VALUE: assert property (
        power_mgmt_enable_out |-> drive_power_mgmt_out != 8'h00)
        else $error("pm enabled at zero");
    AST_RESTART_ONE: assert property (
        reset_restart_out |=> !reset_restart_out)
        else $error("long restart");
    AST_RESTART_LATE: assert property (
        reset_restart_out |-> poll_cnt >= UNIT_CYCLES - 2)
        else $error("early restart");
    AST_READ_VALID: assert property (
        test_mode_out ##1 test_mode_out |-> read_valid_out)
        else $error("read not valid");
    COV_NORMAL: cover property ($rose(normal_mode_out));
    COV_LOAD: cover property (test_load_start_in ##2 test_mode_out);
    COV_RESTART: cover property (reset_restart_out);
endmodule // board_test_pin_control_checker
bind board_test_pin_control board_test_pin_control_checker #(
    .UNIT_CYCLES(UNIT_CYCLES)
) chk (.*);

/* test_board_test_pin_control.sv */
module test_board_test_pin_control;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {string name; int sel; logic [15:0] exp;} note_s;
    logic clk_in = 1'b0, sys_rst_in = 1'b1;
    logic test_load_start_in = 0, test_byte_valid_in = 0, test_read_in = 0;
    logic [7:0] test_byte_in = 8'h00, read_byte_out, eeprom_loc_out;
    logic [2:0] read_index_in = 3'h0, func_addr_in = 3'h0;
    logic read_valid_out, eeprom_req_out, eeprom_ack_in, eeprom_nak_in;
    logic [6:0] eeprom_dev_out;
    logic [7:0] eeprom_data_in, drive_power_mgmt_out;
    logic test_mode_out, normal_mode_out, cfg_done_out;
    logic power_mgmt_enable_out, reset_restart_out;
    logic drive_is_packet_in = 0, drive_has_power_mgmt_in = 0;
    logic reset_poll_start_in = 0, reset_poll_busy_in = 0;
    logic [1:0] func_cs_n_in = 2'h3, disk_cs_n_out;
    logic func_reset_n_in = 1, func_wr_n_in = 1, func_rd_n_in = 1;
    logic func_dack_n_in = 1, func_data_drive_in = 0;
    logic [15:0] func_data_in = 16'h0, disk_data_bus_out, disk_data_bus_in;
    logic [15:0] ext_data = 16'h0;
    logic [2:0] disk_addr_out;
    logic disk_reset_out_n, disk_write_strobe_n_out, disk_read_strobe_n_out;
    logic disk_dma_ack_n_out, disk_data_bus_oe_n_out;
    logic [4:0] pins = 5'h0;
    logic disk_irq_in, disk_io_ready_in, disk_dma_req_in;
    logic disk_iface_enable_in, bus_power_good_in;
    logic ee_present = 1;
    logic [31:0] ee_cfg = 32'h0;
    logic [3:0] ee_lag = 4'h1;
    int seed = 32'hb426;
    int errors = 0, tests_run = 0, gap;
    note_s notes[$];
    note_s n;
    logic [63:0] b;

    always #50 clk_in = ~clk_in;
    assign disk_data_bus_in = disk_data_bus_oe_n_out ? ext_data :
        disk_data_bus_out;
    assign {disk_irq_in, bus_power_good_in, disk_io_ready_in, disk_dma_req_in,
        disk_iface_enable_in} = pins;

    board_test_pin_control #(.UNIT_CYCLES(10)) uut (.*);
    cfg_eeprom_model ee (.clk_in(clk_in), .req_in(eeprom_req_out),
        .dev_in(eeprom_dev_out), .loc_in(eeprom_loc_out),
        .present_in(ee_present), .cfg_in(ee_cfg), .lag_in(ee_lag),
        .ack_out(eeprom_ack_in), .nak_out(eeprom_nak_in),
        .data_out(eeprom_data_in));

    function automatic logic [15:0] pick(int sel);
        case (sel)
            0: pick = 16'(test_mode_out);
            1: pick = 16'({cfg_done_out, normal_mode_out});
            2: pick = 16'(drive_power_mgmt_out);
            3: pick = 16'(power_mgmt_enable_out);
            4: pick = 16'(disk_addr_out);
            5: pick = 16'(disk_cs_n_out);
            6: pick = 16'(disk_reset_out_n);
            7: pick = 16'({disk_dma_ack_n_out, disk_read_strobe_n_out,
                disk_write_strobe_n_out});
            8: pick = disk_data_bus_out;
            9: pick = 16'(disk_data_bus_oe_n_out);
            10: pick = 16'(read_byte_out);
            11: pick = 16'(read_valid_out);
            default: pick = 16'(gap);
        endcase
    endfunction

    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic note(string name, int sel, logic [15:0] exp);
        notes.push_back('{name, sel, exp});
    endtask

    always @(negedge clk_in) begin
        while (notes.size() > 0) begin
            n = notes.pop_front();
            check(n.name, pick(n.sel), n.exp);
        end
    end

    task automatic boot(logic [31:0] cfg, logic present, logic [3:0] lag);
        {ee_cfg, ee_present, ee_lag} <= {cfg, present, lag};
        sys_rst_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        for (int i = 0; i < 200 && test_mode_out !== 1'b1 &&
            normal_mode_out !== 1'b1; i++) @(negedge clk_in);
        repeat (4) @(posedge clk_in);
    endtask

    task automatic load(logic [63:0] v);
        test_load_start_in <= 1'b1;
        @(posedge clk_in);
        test_load_start_in <= 1'b0;
        test_byte_valid_in <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            test_byte_in <= v[8*i +: 8];
            @(posedge clk_in);
        end
        test_byte_valid_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        note("mode", 0, 16'h1);
        note("addr", 4, 16'(v[3:1]));
        note("cs", 5, 16'(v[5:4]));
        note("rst", 6, 16'(v[7]));
        note("strobes", 7, 16'(v[10:8]));
        note("data", 8, v[31:16]);
        note("oe_n", 9, 16'(!v[15]));
    endtask

    task automatic snap(logic rst_bit, logic oe, logic [15:0] dd);
        logic [4:0] v;
        logic [15:0] w;
        logic [7:0] e [8];
        v = 5'($random(seed));
        w = oe ? dd : 16'($random(seed));
        e = '{{rst_bit, v[3], 5'h0, v[4]}, {oe, 1'b0, v[0], v[1], v[2], 3'h0},
            w[7:0], w[15:8], 8'h0, 8'h0, 8'h0, 8'h0};
        pins <= v;
        ext_data <= w;
        repeat (4) @(posedge clk_in);
        test_read_in <= 1'b1;
        @(posedge clk_in);
        test_read_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        pins <= ~v;
        ext_data <= ~w;
        for (int i = 0; i < 8; i++) begin
            read_index_in <= 3'(i);
            repeat (3) @(posedge clk_in);
            note("read", 10, 16'(e[i]));
        end
        note("rvalid", 11, 16'h1);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_in);
        errors++;
        tally_and_finish;
    end

    initial begin
        b = 64'($random(seed)) | 64'h1;
        boot({8'h02, b[7:0], 8'h4d, 8'h4d}, 1'b1, 4'h4);
        note("normal", 1, 16'h3);
        note("test", 0, 16'h0);
        note("pm", 2, 16'(b[7:0]));
        for (int k = 0; k < 4; k++) begin
            {drive_has_power_mgmt_in, drive_is_packet_in} <= 2'(k);
            repeat (4) @(posedge clk_in);
            note("pm_en", 3, 16'(!k[0] && k[1]));
        end
        {func_addr_in, func_cs_n_in, func_data_in} <= 21'($random(seed));
        func_data_drive_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        note("f_addr", 4, 16'(func_addr_in));
        note("f_data", 8, func_data_in);
        note("f_oe_n", 9, 16'h0);
        {reset_poll_start_in, reset_poll_busy_in} <= 2'h3;
        @(posedge clk_in);
        reset_poll_start_in <= 1'b0;
        for (gap = 0; gap < 60 && reset_restart_out !== 1'b1; gap++)
            @(negedge clk_in);
        note("restart_at", 12, 16'd22);
        @(posedge clk_in);
        reset_poll_start_in <= 1'b1;
        @(posedge clk_in);
        reset_poll_start_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        reset_poll_busy_in <= 1'b0;
        gap = 0;
        repeat (40) begin
            @(negedge clk_in);
            gap += int'(reset_restart_out === 1'b1);
        end
        @(posedge clk_in);
        note("cancel", 12, 16'h0);
        $display("test normal done");
        for (int k = 0; k < 2; k++) begin
            b = {$random(seed), $random(seed)};
            b[15] = k == 0;
            b[63:56] = ~b[7:0];
            load(b);
            snap(b[7], b[15], b[31:16]);
        end
        $display("test load_read done");
        boot({16'h0000, 8'h4c, 8'h4d}, 1'b1, 4'h1);
        note("badsig", 0, 16'h1);
        note("idle_cs", 5, 16'h3);
        note("idle_oe", 9, 16'h1);
        boot(32'h02004d4d, 1'b0, 4'h2);
        note("absent", 0, 16'h1);
        note("absent_n", 1, 16'h2);
        boot(32'h02004d4d, 1'b1, 4'h1);
        note("pm_off", 3, 16'h0);
        $display("test fallback done");
        @(posedge clk_in);
        tally_and_finish;
    end
endmodule // test_board_test_pin_control
